// [rtl/psp_serial_port.sv]
`timescale 1ns/1ps
`include "psp_params.svh"
// Functional notes
// - Idle bus leaves SDA and SCL high; device releases SDA whenever idle.
// - SDA falling while SCL high is a start; device begins a transfer.
// - First byte is 7-bit address plus direction bit, 0 write, 1 read.
// - Bytes are 8 bits, MSB first, one clock pulse per bit.
// - Receiver acknowledges by pulling SDA low on the ninth clock pulse.
// - Master not acknowledging stops device transmit; master resends or stops.
// - Transmitter changes SDA only while SCL is low.
// - SDA rising while SCL high is a stop; device ends the transfer.
// - After reset device is idle, waiting for a command.
// - While a command is clocked in, SPI returns status then two undefined bytes.
// - Measurement command drives end-of-conversion low and enters active state.
// - On completion results are stored, device idles, EOC high, busy cleared.
// - Status read command is answered with status in idle or active state.
// - Four coefficients are 32-bit signed, three are 8-bit signed.
// - Coefficient words are fetched one address each, high word first.
// - Status holds bit7 zero, power, busy, mode, memory error, arithmetic error.
// - Measurement read gives status, 24-bit pressure, 24-bit temperature, MSB first.
module psp_serial_port import psp_pkg::*; (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OEN_O,
  input wire logic SCLK_I,
  input wire logic SS_N_I,
  input wire logic MOSI_I,
  output logic MISO_O,
  output logic MISO_OEN_O,
  output logic EOC_O,
  input wire logic [6:0] DEV_ADDR_I,
  output logic MEAS_START_O,
  input wire logic MEAS_DONE_I,
  input wire logic [23:0] PRESS_I,
  input wire logic [23:0] TEMP_I,
  input wire logic ALU_ERR_I,
  output logic MEM_RD_O,
  output logic [7:0] MEM_ADDR_O,
  input wire logic MEM_VALID_I,
  input wire logic [15:0] MEM_DATA_I,
  input wire logic MEM_ERR_I
);
  logic [`PSP_PIN_W-1:0] pin_lvl, pin_rise, pin_fall;
  logic scl_lvl, scl_rise, scl_fall, sda_lvl, start_w, stop_w;
  logic ss_lvl, ss_fall, sclk_rise, sclk_fall, mosi_lvl;
  psp_core_st_t c_st_r, c_st_nxt;
  logic eoc_r, eoc_nxt, meas_start_r, meas_start_nxt, mem_rd_r, mem_rd_nxt;
  logic mem_mode_r, mem_mode_nxt, alu_r, alu_nxt;
  logic [7:0] mem_addr_r, mem_addr_nxt;
  logic [23:0] res_p_r, res_p_nxt, res_t_r, res_t_nxt;
  logic [15:0] mem_word_r, mem_word_nxt;
  logic [7:0] status_w, cmd_b, tx_i_w, tx_s_w;
  logic cmd_stb;
  psp_i2c_st_t i_st_r, i_st_nxt;
  logic [7:0] i_sh_r, i_sh_nxt, i_tx_r, i_tx_nxt;
  logic [3:0] i_cnt_r, i_cnt_nxt;
  logic [2:0] i_idx_r, i_idx_nxt;
  logic i_rw_r, i_rw_nxt, sda_oen_r, sda_oen_nxt, i_cmd_r, i_cmd_nxt;
  logic [7:0] s_sh_r, s_sh_nxt, s_tx_r, s_tx_nxt;
  logic [2:0] s_cnt_r, s_cnt_nxt, s_idx_r, s_idx_nxt;
  logic s_rd_r, s_rd_nxt, miso_r, miso_nxt, miso_oen_r, miso_oen_nxt;
  logic s_cmd_r, s_cmd_nxt;

  psp_pin_sync psp_pin_sync_i (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .CE_I(CE_I),
    .PIN_I({SS_N_I, SCLK_I, MOSI_I, SDA_I, SCL_I}),
    .LVL_O(pin_lvl),
    .RISE_O(pin_rise),
    .FALL_O(pin_fall)
  );

  assign scl_lvl = pin_lvl[`PSP_PIN_SCL];
  assign scl_rise = pin_rise[`PSP_PIN_SCL];
  assign scl_fall = pin_fall[`PSP_PIN_SCL];
  assign sda_lvl = pin_lvl[`PSP_PIN_SDA];
  assign start_w = scl_lvl & pin_fall[`PSP_PIN_SDA];
  assign stop_w = scl_lvl & pin_rise[`PSP_PIN_SDA];
  assign ss_lvl = pin_lvl[`PSP_PIN_SS];
  assign ss_fall = pin_fall[`PSP_PIN_SS];
  assign sclk_rise = pin_rise[`PSP_PIN_SCLK];
  assign sclk_fall = pin_fall[`PSP_PIN_SCLK];
  assign mosi_lvl = pin_lvl[`PSP_PIN_MOSI];

  function automatic psp_cmd_t cmd_kind(input logic [7:0] b);
    if (b == `PSP_CMD_READ) return K_READ;
    else if (b[7:4] == `PSP_MEAS_NIB) return K_MEAS;
    else if (b >= `PSP_MEM_ADDR_MIN && b <= `PSP_MEM_ADDR_MAX) return K_MEM;
    else return K_NONE;
  endfunction

  // Byte idx of the read stream; memory mode sends status, high, low
  function automatic logic [7:0] tx_byte(input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'h0: b = status_w;
      3'h1: b = mem_mode_r ? mem_word_r[15:8] : res_p_r[23:16];
      3'h2: b = mem_mode_r ? mem_word_r[7:0] : res_p_r[15:8];
      3'h3: b = mem_mode_r ? 8'h00 : res_p_r[7:0];
      3'h4: b = mem_mode_r ? 8'h00 : res_t_r[23:16];
      3'h5: b = mem_mode_r ? 8'h00 : res_t_r[15:8];
      3'h6: b = mem_mode_r ? 8'h00 : res_t_r[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic logic [2:0] idx_inc(input logic [2:0] idx);
    return (idx == `PSP_IDX_MAX) ? idx : idx + 3'h1;
  endfunction

  always_comb begin
    status_w = 8'h00;
    status_w[`PSP_ST_POWER] = 1'b1;
    status_w[`PSP_ST_BUSY] = (c_st_r == C_ACTIVE);
    status_w[`PSP_ST_MODE_HI:`PSP_ST_MODE_LO] = `PSP_MODE_NORMAL;
    status_w[`PSP_ST_MEMERR] = MEM_ERR_I;
    status_w[`PSP_ST_ALUERR] = alu_r;
  end

  // A process, not an assign: the byte must follow status and results read inside the function
  always_comb begin
    tx_i_w = tx_byte(i_idx_r);
    tx_s_w = s_rd_r ? tx_byte(s_idx_r) : 8'h00;
  end
  // I2C wins if both links deliver a command in the same cycle
  assign cmd_stb = i_cmd_r | s_cmd_r;
  assign cmd_b = i_cmd_r ? i_sh_r : s_sh_r;

  // Measurement and memory core
  always_comb begin
    c_st_nxt = c_st_r;
    eoc_nxt = eoc_r;
    meas_start_nxt = 1'b0;
    mem_rd_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_mode_nxt = mem_mode_r;
    res_p_nxt = res_p_r;
    res_t_nxt = res_t_r;
    alu_nxt = alu_r;
    mem_word_nxt = MEM_VALID_I ? MEM_DATA_I : mem_word_r;
    unique case (c_st_r)
      C_IDLE: begin
        // Commands arriving during a conversion are dropped
        if (cmd_stb) begin
          unique case (cmd_kind(cmd_b))
            K_MEAS: begin
              c_st_nxt = C_ACTIVE;
              eoc_nxt = 1'b0;
              meas_start_nxt = 1'b1;
              mem_mode_nxt = 1'b0;
            end
            K_MEM: begin
              mem_addr_nxt = cmd_b;
              mem_rd_nxt = 1'b1;
              mem_mode_nxt = 1'b1;
            end
            K_READ, K_NONE: begin
            end
          endcase
        end
      end
      C_ACTIVE: begin
        if (MEAS_DONE_I) begin
          res_p_nxt = PRESS_I;
          res_t_nxt = TEMP_I;
          alu_nxt = ALU_ERR_I;
          eoc_nxt = 1'b1;
          c_st_nxt = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      c_st_r <= C_IDLE;
      eoc_r <= `PSP_EOC_RST;
      meas_start_r <= 1'b0;
      mem_rd_r <= 1'b0;
      mem_addr_r <= 8'h00;
      mem_mode_r <= 1'b0;
      res_p_r <= `PSP_RES_RST;
      res_t_r <= `PSP_RES_RST;
      alu_r <= 1'b0;
      mem_word_r <= `PSP_MEM_RST;
    end else if (CE_I) begin
      c_st_r <= c_st_nxt;
      eoc_r <= eoc_nxt;
      meas_start_r <= meas_start_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_mode_r <= mem_mode_nxt;
      res_p_r <= res_p_nxt;
      res_t_r <= res_t_nxt;
      alu_r <= alu_nxt;
      mem_word_r <= mem_word_nxt;
    end
  end

  // I2C target; SDA is only ever pulled low, a one bit releases it
  always_comb begin
    i_st_nxt = i_st_r;
    i_sh_nxt = i_sh_r;
    i_tx_nxt = i_tx_r;
    i_cnt_nxt = i_cnt_r;
    i_idx_nxt = i_idx_r;
    i_rw_nxt = i_rw_r;
    sda_oen_nxt = sda_oen_r;
    i_cmd_nxt = 1'b0;
    if (stop_w) begin
      i_st_nxt = I_IDLE;
      sda_oen_nxt = 1'b1;
    end else if (start_w) begin
      i_st_nxt = I_ADDR;
      i_cnt_nxt = 4'h0;
      sda_oen_nxt = 1'b1;
    end else begin
      unique case (i_st_r)
        I_IDLE, I_WAIT: sda_oen_nxt = 1'b1;
        I_ADDR, I_WRX: begin
          if (scl_rise) begin
            i_sh_nxt = {i_sh_r[6:0], sda_lvl};
            i_cnt_nxt = i_cnt_r + 4'h1;
          end else if (scl_fall && i_cnt_r == `PSP_I2C_BITS) begin
            i_cnt_nxt = 4'h0;
            if (i_st_r == I_ADDR) begin
              if (i_sh_r[7:1] == DEV_ADDR_I) begin
                i_rw_nxt = i_sh_r[0];
                i_idx_nxt = 3'h0;
                sda_oen_nxt = 1'b0;
                i_st_nxt = I_ACK;
              end else begin
                i_st_nxt = I_WAIT;
              end
            end else begin
              // Only the first written byte is a command
              i_cmd_nxt = (i_idx_r == 3'h0);
              i_idx_nxt = idx_inc(i_idx_r);
              sda_oen_nxt = 1'b0;
              i_st_nxt = I_ACK;
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            i_cnt_nxt = 4'h0;
            if (i_rw_r) begin
              i_tx_nxt = tx_i_w;
              sda_oen_nxt = tx_i_w[7];
              i_st_nxt = I_TX;
            end else begin
              sda_oen_nxt = 1'b1;
              i_st_nxt = I_WRX;
            end
          end
        end
        I_TX: begin
          if (scl_rise) begin
            i_cnt_nxt = i_cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (i_cnt_r == `PSP_I2C_BITS) begin
              sda_oen_nxt = 1'b1;
              i_st_nxt = I_RACK;
            end else begin
              i_tx_nxt = {i_tx_r[6:0], 1'b0};
              sda_oen_nxt = i_tx_r[6];
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            if (sda_lvl) i_st_nxt = I_WAIT;
            else i_idx_nxt = idx_inc(i_idx_r);
          end else if (scl_fall) begin
            i_cnt_nxt = 4'h0;
            i_tx_nxt = tx_i_w;
            sda_oen_nxt = tx_i_w[7];
            i_st_nxt = I_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      i_st_r <= I_IDLE;
      i_sh_r <= 8'h00;
      i_tx_r <= 8'h00;
      i_cnt_r <= 4'h0;
      i_idx_r <= 3'h0;
      i_rw_r <= 1'b0;
      sda_oen_r <= 1'b1;
      i_cmd_r <= 1'b0;
    end else if (CE_I) begin
      i_st_r <= i_st_nxt;
      i_sh_r <= i_sh_nxt;
      i_tx_r <= i_tx_nxt;
      i_cnt_r <= i_cnt_nxt;
      i_idx_r <= i_idx_nxt;
      i_rw_r <= i_rw_nxt;
      sda_oen_r <= sda_oen_nxt;
      i_cmd_r <= i_cmd_nxt;
    end
  end

  // SPI mode 0: sample on SCLK rise, shift out on fall
  always_comb begin
    logic [7:0] sh_new;
    sh_new = {s_sh_r[6:0], mosi_lvl};
    s_sh_nxt = s_sh_r;
    s_tx_nxt = s_tx_r;
    s_cnt_nxt = s_cnt_r;
    s_idx_nxt = s_idx_r;
    s_rd_nxt = s_rd_r;
    miso_nxt = miso_r;
    miso_oen_nxt = miso_oen_r;
    s_cmd_nxt = 1'b0;
    if (ss_fall) begin
      s_cnt_nxt = 3'h0;
      s_idx_nxt = 3'h0;
      s_rd_nxt = 1'b0;
      s_tx_nxt = status_w;
      miso_nxt = status_w[7];
      miso_oen_nxt = 1'b0;
    end else if (ss_lvl) begin
      miso_oen_nxt = 1'b1;
    end else if (sclk_rise) begin
      s_sh_nxt = sh_new;
      s_cnt_nxt = s_cnt_r + 3'h1;
      if (s_cnt_r == `PSP_SPI_LAST_BIT) begin
        if (s_idx_r == 3'h0) begin
          s_rd_nxt = (cmd_kind(sh_new) == K_READ);
          s_cmd_nxt = (cmd_kind(sh_new) != K_READ);
        end
        s_idx_nxt = idx_inc(s_idx_r);
      end
    end else if (sclk_fall) begin
      if (s_cnt_r == 3'h0) begin
        s_tx_nxt = tx_s_w;
        miso_nxt = tx_s_w[7];
      end else begin
        s_tx_nxt = {s_tx_r[6:0], 1'b0};
        miso_nxt = s_tx_r[6];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      s_sh_r <= 8'h00;
      s_tx_r <= 8'h00;
      s_cnt_r <= 3'h0;
      s_idx_r <= 3'h0;
      s_rd_r <= 1'b0;
      miso_r <= 1'b0;
      miso_oen_r <= 1'b1;
      s_cmd_r <= 1'b0;
    end else if (CE_I) begin
      s_sh_r <= s_sh_nxt;
      s_tx_r <= s_tx_nxt;
      s_cnt_r <= s_cnt_nxt;
      s_idx_r <= s_idx_nxt;
      s_rd_r <= s_rd_nxt;
      miso_r <= miso_nxt;
      miso_oen_r <= miso_oen_nxt;
      s_cmd_r <= s_cmd_nxt;
    end
  end

  // Open drain: the data flop never drives a one
  always_ff @(posedge CLK_I) begin
    SDA_O <= 1'b0;
  end

  assign SDA_OEN_O = sda_oen_r;
  assign MISO_O = miso_r;
  assign MISO_OEN_O = miso_oen_r;
  assign EOC_O = eoc_r;
  assign MEAS_START_O = meas_start_r;
  assign MEM_RD_O = mem_rd_r;
  assign MEM_ADDR_O = mem_addr_r;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I || !CE_I);

  a_idle_release: assert property (
    i_st_r inside {I_IDLE, I_WAIT} |-> sda_oen_r) else $error("SDA held while idle");
  a_start_seen: assert property (
    start_w && !stop_w |=> i_st_r == I_ADDR && i_cnt_r == 4'h0) else $error("start missed");
  a_addr_ack: assert property (
    i_st_r == I_ADDR && scl_fall && i_cnt_r == 4'h8 && i_sh_r[7:1] == DEV_ADDR_I && !start_w
    && !stop_w |=> !sda_oen_r && i_rw_r == $past(i_sh_r[0])) else $error("no address ack");
  a_foreign_addr: assert property (
    i_st_r == I_ADDR && scl_fall && i_cnt_r == 4'h8 && i_sh_r[7:1] != DEV_ADDR_I && !start_w
    && !stop_w |=> i_st_r == I_WAIT ##1 sda_oen_r) else $error("foreign address answered");
  a_nack_quit: assert property (
    i_st_r == I_RACK && scl_rise && sda_lvl && !start_w && !stop_w
    |=> i_st_r == I_WAIT && sda_oen_r) else $error("transmit after nack");
  a_sda_low_phase: assert property (
    $changed(sda_oen_r) && !$past(start_w || stop_w) |-> !$past(scl_lvl))
    else $error("SDA moved with SCL high");
  a_byte_len: assert property (
    i_st_r == I_TX && scl_fall && i_cnt_r == 4'h8 && !start_w && !stop_w
    |=> i_st_r == I_RACK && sda_oen_r) else $error("byte length wrong");
  a_stop_end: assert property (
    stop_w |=> i_st_r == I_IDLE && sda_oen_r) else $error("stop ignored");
  a_meas_start: assert property (
    cmd_stb && c_st_r == C_IDLE && cmd_kind(cmd_b) == K_MEAS
    |=> !EOC_O && MEAS_START_O && status_w[5]) else $error("measurement not started");
  a_meas_done: assert property (
    c_st_r == C_ACTIVE && MEAS_DONE_I |=> EOC_O && !status_w[5] && res_p_r == $past(PRESS_I))
    else $error("completion not reflected");
  a_idle_eoc: assert property (
    c_st_r == C_IDLE |-> EOC_O) else $error("EOC low while idle");
  a_spi_status: assert property (
    ss_fall |=> !MISO_OEN_O && MISO_O == $past(status_w[7])) else $error("status not first");
  a_status_fmt: assert property (
    !status_w[7] && status_w[6] && status_w[4:3] == 2'h0 && !status_w[1])
    else $error("status layout");
  a_mem_req: assert property (
    cmd_stb && c_st_r == C_IDLE && cmd_kind(cmd_b) == K_MEM
    |=> MEM_RD_O && MEM_ADDR_O == $past(cmd_b) && mem_mode_r) else $error("memory request lost");

  c_meas_done: cover property (c_st_r == C_ACTIVE && MEAS_DONE_I);
  c_i2c_nack: cover property (i_st_r == I_RACK && scl_rise && sda_lvl);
  c_spi_read: cover property (!s_rd_r ##1 s_rd_r);
  c_mem_req: cover property (MEM_RD_O);
endmodule

// [rtl/psp_params.svh]
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH

// Synchronised pin vector positions
`define PSP_PIN_SCL 0
`define PSP_PIN_SDA 1
`define PSP_PIN_MOSI 2
`define PSP_PIN_SCLK 3
`define PSP_PIN_SS 4
`define PSP_PIN_W 5
// Reset level of {ss_n, sclk, mosi, sda, scl}: ss_n, sda and scl idle high, sclk and mosi low
`define PSP_PIN_IDLE 5'h13

// Command decode
`define PSP_CMD_READ 8'hF0
`define PSP_MEAS_NIB 4'hA
`define PSP_MEM_ADDR_MIN 8'h2F
`define PSP_MEM_ADDR_MAX 8'h38

// Status byte layout
`define PSP_ST_POWER 6
`define PSP_ST_BUSY 5
`define PSP_ST_MODE_HI 4
`define PSP_ST_MODE_LO 3
`define PSP_ST_MEMERR 2
`define PSP_ST_ALUERR 0
`define PSP_MODE_NORMAL 2'h0

// Bits per I2C byte, last SPI bit index, last byte index of the read stream
`define PSP_I2C_BITS 4'h8
`define PSP_SPI_LAST_BIT 3'h7
`define PSP_IDX_MAX 3'h7

// Reset values
`define PSP_EOC_RST 1'b1
`define PSP_RES_RST 24'h000000
`define PSP_MEM_RST 16'h0000

`endif

// [rtl/psp_pkg.sv]
package psp_pkg;

  typedef enum logic [6:0] {
    I_IDLE = 7'h01,
    I_ADDR = 7'h02,
    I_ACK = 7'h04,
    I_WRX = 7'h08,
    I_TX = 7'h10,
    I_RACK = 7'h20,
    I_WAIT = 7'h40
  } psp_i2c_st_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'h1,
    C_ACTIVE = 2'h2
  } psp_core_st_t;

  typedef enum logic [3:0] {
    K_NONE = 4'h1,
    K_MEAS = 4'h2,
    K_MEM = 4'h4,
    K_READ = 4'h8
  } psp_cmd_t;

endpackage

// [rtl/psp_pin_sync.sv]
`timescale 1ns/1ps
`include "psp_params.svh"
module psp_pin_sync (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic [`PSP_PIN_W-1:0] PIN_I,
  output logic [`PSP_PIN_W-1:0] LVL_O,
  output logic [`PSP_PIN_W-1:0] RISE_O,
  output logic [`PSP_PIN_W-1:0] FALL_O
);
  logic [`PSP_PIN_W-1:0] meta_r;
  logic [`PSP_PIN_W-1:0] lvl_r;
  logic [`PSP_PIN_W-1:0] prev_r;

  // Edges are taken between the second and third stage only
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      meta_r <= `PSP_PIN_IDLE;
      lvl_r <= `PSP_PIN_IDLE;
      prev_r <= `PSP_PIN_IDLE;
    end else if (CE_I) begin
      meta_r <= PIN_I;
      lvl_r <= meta_r;
      prev_r <= lvl_r;
    end
  end

  assign LVL_O = lvl_r;
  assign RISE_O = lvl_r & ~prev_r;
  assign FALL_O = ~lvl_r & prev_r;
endmodule

// [tb/psp_host_model.sv]
`timescale 1ns/1ps
module psp_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  input wire logic miso_i,
  output logic scl_o,
  output logic sda_oen_o,
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o
);
  // Half of the 400 ns link period at 50 ns per cycle
  localparam int HALF = 4;

  initial begin
    scl_o = 1'b1;
    sda_oen_o = 1'b1;
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Also serves as a repeated start when SCL is low
  task automatic i2c_start();
    wait_cyc(HALF / 2);
    sda_oen_o <= 1'b1;
    wait_cyc(HALF / 2);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    sda_oen_o <= 1'b0;
    wait_cyc(HALF);
    scl_o <= 1'b0;
  endtask

  task automatic i2c_bit(input logic tx, output logic rx);
    wait_cyc(HALF / 2);
    sda_oen_o <= tx;
    wait_cyc(HALF / 2);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    rx = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic i2c_stop();
    wait_cyc(HALF / 2);
    sda_oen_o <= 1'b0;
    wait_cyc(HALF / 2);
    scl_o <= 1'b1;
    wait_cyc(HALF);
    sda_oen_o <= 1'b1;
    wait_cyc(HALF);
  endtask

  task automatic i2c_wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], r);
    end
    i2c_bit(1'b1, ack);
  endtask

  task automatic i2c_rd(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, b[i]);
    end
    i2c_bit(nack, r);
  endtask

  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o <= tx[i];
      wait_cyc(HALF);
      sclk_o <= 1'b1;
      wait_cyc(HALF);
      rx[i] = miso_i;
      sclk_o <= 1'b0;
    end
  endtask

  task automatic spi_frame(input logic [7:0] cmd, input int n, output logic [55:0] rx);
    logic [7:0] b;
    rx = '0;
    ss_n_o <= 1'b0;
    for (int k = 0; k < n; k++) begin
      spi_byte((k == 0) ? cmd : 8'h00, b);
      rx = {rx[47:0], b};
    end
    wait_cyc(HALF);
    ss_n_o <= 1'b1;
    // Deselected line must not keep showing the last bit
    mosi_o <= ~mosi_o;
    wait_cyc(2 * HALF);
  endtask
endmodule

// [tb/psp_serial_port_tb.sv]
`timescale 1ns/1ps
module psp_serial_port_tb;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [23:0] P_VAL = 24'h81A2C3;
  localparam logic [23:0] T_VAL = 24'h5E6F70;
  logic clk, nrst, scl, sda_host, sclk, ss_n, mosi;
  logic sda_o, sda_oen, miso, miso_oen, eoc, meas_start, mem_rd;
  logic meas_done, alu_err, mem_valid, mem_err, ce;
  logic [7:0] mem_addr, last_mem_addr;
  logic [23:0] press, temp;
  logic [15:0] mem_data;
  wire logic sda, miso_w;
  int n_mismatch, check_count, n_start, n_mem;

  // Open-drain line with pull-up
  assign sda = sda_host & (sda_oen ? 1'b1 : sda_o);
  // Undriven MISO shows the wrong level so a late enable is caught
  assign miso_w = miso_oen ? ~miso : miso;

  psp_serial_port psp_serial_port_i (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OEN_O(sda_oen), .SCLK_I(sclk),
    .SS_N_I(ss_n), .MOSI_I(mosi), .MISO_O(miso), .MISO_OEN_O(miso_oen), .EOC_O(eoc),
    .DEV_ADDR_I(ADDR), .MEAS_START_O(meas_start), .MEAS_DONE_I(meas_done),
    .PRESS_I(press), .TEMP_I(temp), .ALU_ERR_I(alu_err), .MEM_RD_O(mem_rd),
    .MEM_ADDR_O(mem_addr), .MEM_VALID_I(mem_valid), .MEM_DATA_I(mem_data),
    .MEM_ERR_I(mem_err));

  psp_host_model psp_host_model_i (.clk_i(clk), .sda_i(sda), .miso_i(miso_w),
    .scl_o(scl), .sda_oen_o(sda_host), .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulse counters and a memory that answers one cycle after the request
  always @(posedge clk) begin
    if (meas_start === 1'b1) begin
      n_start++;
    end
    if (mem_rd === 1'b1) begin
      n_mem++;
      last_mem_addr = mem_addr;
    end
    mem_valid <= (mem_rd === 1'b1);
    mem_data <= {mem_addr, ~mem_addr};
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic i2c_cmd(input logic [6:0] a, input logic [7:0] c, output logic ack);
    logic k;
    psp_host_model_i.i2c_start();
    psp_host_model_i.i2c_wr({a, 1'b0}, ack);
    psp_host_model_i.i2c_wr(c, k);
    psp_host_model_i.i2c_stop();
  endtask

  task automatic i2c_read(input int n, output logic [55:0] rx);
    logic ack;
    logic [7:0] b;
    rx = '0;
    psp_host_model_i.i2c_start();
    psp_host_model_i.i2c_wr({ADDR, 1'b1}, ack);
    chk("read address ack", 1'b0, ack);
    for (int i = 0; i < n; i++) begin
      psp_host_model_i.i2c_rd(i == n - 1, b);
      rx = {rx[47:0], b};
    end
    psp_host_model_i.i2c_stop();
    chk("sda released after stop", 1'b1, sda_oen);
  endtask

  task automatic finish_conv(input logic alu);
    @(posedge clk);
    press <= P_VAL;
    temp <= T_VAL;
    alu_err <= alu;
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    press <= ~P_VAL;
    temp <= ~T_VAL;
    repeat (3) @(posedge clk);
    chk("eoc after done", 1'b1, eoc);
  endtask

  task automatic t_reset();
    logic [55:0] rx;
    chk("idle sda", 1'b1, sda);
    chk("eoc after reset", 1'b1, eoc);
    chk("miso enable after reset", 1'b1, miso_oen);
    i2c_read(1, rx);
    chk("status after reset", 8'h40, rx[7:0]);
    $display("test reset done");
  endtask

  task automatic t_i2c_meas();
    logic ack;
    logic [55:0] rx;
    int s0;
    s0 = n_start;
    i2c_cmd(ADDR, 8'hAD, ack);
    chk("address ack", 1'b0, ack);
    chk("start pulses", s0 + 1, n_start);
    chk("eoc while busy", 1'b0, eoc);
    @(posedge clk);
    ce <= 1'b0;
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("eoc frozen", 1'b0, eoc);
    i2c_read(1, rx);
    chk("busy status", 8'h60, rx[7:0]);
    finish_conv(1'b0);
    i2c_read(7, rx);
    chk("status byte", 8'h40, rx[55:48]);
    chk("pressure", P_VAL, rx[47:24]);
    chk("temperature", T_VAL, rx[23:0]);
    s0 = n_start;
    i2c_cmd(ADDR ^ 7'h01, 8'hA0, ack);
    chk("foreign address ack", 1'b1, ack);
    chk("foreign address start", s0, n_start);
    $display("test i2c measurement done");
  endtask

  task automatic t_spi_meas();
    logic [55:0] rx;
    int s0;
    s0 = n_start;
    psp_host_model_i.spi_frame(8'hA5, 3, rx);
    chk("spi command status", 8'h40, rx[23:16]);
    chk("spi start pulses", s0 + 1, n_start);
    chk("spi eoc busy", 1'b0, eoc);
    psp_host_model_i.spi_frame(8'hF0, 1, rx);
    chk("spi busy status", 8'h60, rx[7:0]);
    finish_conv(1'b1);
    psp_host_model_i.spi_frame(8'hF0, 7, rx);
    chk("spi status", 8'h41, rx[55:48]);
    chk("spi pressure", P_VAL, rx[47:24]);
    chk("spi temperature", T_VAL, rx[23:0]);
    chk("miso released", 1'b1, miso_oen);
    $display("test spi measurement done");
  endtask

  task automatic t_mem();
    logic ack;
    logic [55:0] rx;
    mem_err <= 1'b1;
    i2c_cmd(ADDR, 8'h2F, ack);
    chk("mem address", 8'h2F, last_mem_addr);
    i2c_read(3, rx);
    chk("mem status", 8'h45, rx[23:16]);
    chk("mem word", 16'h2FD0, rx[15:0]);
    for (int a = 8'h2F; a <= 8'h38; a++) begin
      psp_host_model_i.spi_frame(a[7:0], 3, rx);
      chk("spi mem address", a[7:0], last_mem_addr);
      psp_host_model_i.spi_frame(8'hF0, 3, rx);
      chk("spi mem word", {a[7:0], ~a[7:0]}, rx[15:0]);
    end
    chk("mem requests", 11, n_mem);
    $display("test memory done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    meas_done = 1'b0;
    alu_err = 1'b0;
    mem_err = 1'b0;
    mem_valid = 1'b0;
    mem_data = 16'h0000;
    press = 24'h000000;
    temp = 24'h000000;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_i2c_meas();
    t_spi_meas();
    t_mem();
    give_verdict();
  end

  // Whole run needs about 6600 cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
